// ---- inc/acr_pkg.sv ----
// Package for the converter control and result register block.
// Assumes a byte-wide register port and one 200 MHz bus clock.
package acr_pkg;
    // Register offsets (byte addresses on the plain port)
    localparam logic [7:0] ACR_OFF_STATUS_CONTROL = 8'h3C;
    localparam logic [7:0] ACR_OFF_RESULT_HIGH = 8'h3D;
    localparam logic [7:0] ACR_OFF_RESULT_LOW = 8'h3E;
    localparam logic [7:0] ACR_OFF_CLOCK_CONTROL = 8'h3F;
    // Status/control field positions
    localparam int ACR_POS_DONE = 7;
    localparam int ACR_POS_IEN = 6;
    localparam int ACR_POS_CONT = 5;
    // Clock control field positions
    localparam int ACR_POS_PRESCALE = 5;
    localparam int ACR_POS_SOURCE = 4;
    localparam int ACR_POS_JUST = 2;
    // Reset values
    localparam logic [4:0] ACR_RST_INPUT_SELECT = 5'h1F;
    localparam logic [2:0] ACR_RST_PRESCALE = 3'h0;
    localparam logic [1:0] ACR_RST_JUST = 2'h1;
    localparam logic [7:0] ACR_RST_RESULT = 8'h00;
    // Channel codes
    localparam logic [4:0] ACR_CH_LAST_PIN = 5'h05;
    localparam logic [4:0] ACR_CH_BANDGAP = 5'h1A;
    localparam logic [4:0] ACR_CH_REF_HIGH = 5'h1D;
    localparam logic [4:0] ACR_CH_REF_LOW = 5'h1E;
    localparam logic [4:0] ACR_CH_POWER_OFF = 5'h1F;
    // Conversion length in converter clock periods
    localparam logic [4:0] ACR_CONV_CYCLES = 5'h10;
    // Justification modes
    typedef enum logic [1:0] {
        ACR_JUST_TRUNC = 2'h0,
        ACR_JUST_RIGHT = 2'h1,
        ACR_JUST_LEFT = 2'h2,
        ACR_JUST_SIGN = 2'h3
    } acr_just_t;
    // Converter sequencer states
    typedef enum logic [2:0] {
        ACR_ST_IDLE = 3'h1,
        ACR_ST_RUN = 3'h2,
        ACR_ST_OFF = 3'h4
    } acr_state_t;
endpackage : acr_pkg

// ---- inc/acr_core_if.sv ----
// Start/result carrier between the control logic and the converter core model.
// Assumes one clock shared by both ends.
`timescale 1ns/10ps
interface acr_core_if;
    logic start;
    logic [4:0] channel;
    logic [9:0] result;
    logic done;
    modport ctrl (output start, output channel, input result, input done);
    modport core (input start, input channel, output result, output done);
endinterface : acr_core_if

// ---- hw/acr_clkdiv.sv ----
// Converter clock prescaler: one-cycle enable pulses at the divided rate.
// Assumes the input clock enable is high on each input clock period.
`timescale 1ns/10ps
module acr_clkdiv
    import acr_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic restart,
    input wire logic src_en,
    input wire logic [2:0] prescale,
    output logic tick
);
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic next_tick;
    logic [3:0] limit;

    ////////////////////////////////////////////////////////////////////////
    // Divide ratio: 1,2,4,8, and 16 whenever the top code bit is set
    always_comb begin
        limit = prescale[2] ? 4'hF : 4'((4'h1 << prescale[1:0]) - 4'h1);
        next_cnt = cnt;
        next_tick = 1'b0;
        if (restart) begin
            next_cnt = 4'h0;
        end else if (src_en) begin
            if (cnt >= limit) begin
                next_cnt = 4'h0;
                next_tick = 1'b1;
            end else begin
                next_cnt = cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt <= 4'h0;
            tick <= 1'b0;
        end else begin
            cnt <= next_cnt;
            tick <= next_tick;
        end
    end
endmodule : acr_clkdiv

// ---- hw/acr_core.sv ----
// Behavioural stand-in for the analog comparator core.
// Assumes the analog sample arrives as a 10-bit code per selected input.
`timescale 1ns/10ps
module acr_core
    import acr_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic [9:0] sample,
    acr_core_if.core cif
);
    logic [4:0] cnt;
    logic [4:0] next_cnt;
    logic busy;
    logic next_busy;
    logic [9:0] next_result;
    logic next_done;

    ////////////////////////////////////////////////////////////////////////
    // Count sixteen converter clocks; the prescaler restarts with the start pulse
    always_comb begin
        next_cnt = cnt;
        next_busy = busy;
        next_done = 1'b0;
        next_result = cif.result;
        if (cif.start) begin
            next_cnt = 5'h0;
            next_busy = 1'b1;
        end else if (busy && tick) begin
            if (cnt == ACR_CONV_CYCLES - 5'h1) begin
                next_busy = 1'b0;
                next_done = 1'b1;
                next_result = sample;
            end else begin
                next_cnt = cnt + 5'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt <= 5'h0;
            busy <= 1'b0;
            cif.done <= 1'b0;
            cif.result <= 10'h000;
        end else begin
            cnt <= next_cnt;
            busy <= next_busy;
            cif.done <= next_done;
            cif.result <= next_result;
        end
    end
endmodule : acr_core

// ---- hw/acr_top.sv ----
// Converter control, channel select and result formatting registers.
// Assumes a plain byte register port, read data one cycle after the strobe,
// and analog input samples presented as 10-bit codes.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/10ps
module acr_top
    import acr_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic XTAL_EN,
    input wire logic [59:0] PIN_SAMPLE,
    input wire logic [9:0] BANDGAP_SAMPLE,
    output logic IRQ,
    output logic [5:0] PIN_CLAIM,
    output logic POWER_DOWN
);
    acr_core_if cif ();

    logic done_flag;
    logic done_interrupt_enable;
    logic continuous_convert;
    logic [4:0] input_select;
    logic [2:0] clock_prescale;
    logic input_clock_source;
    acr_just_t justify;
    logic [7:0] result_high_byte;
    logic [7:0] result_low_byte;
    logic frozen;
    acr_state_t state;
    logic irq_q;

    logic next_done_flag;
    logic next_ien;
    logic next_cont;
    logic [4:0] next_input_select;
    logic [2:0] next_prescale;
    logic next_source;
    acr_just_t next_justify;
    logic [7:0] next_high;
    logic [7:0] next_low;
    logic next_frozen;
    acr_state_t next_state;
    logic next_irq;
    logic next_start;
    logic [4:0] next_channel;
    logic [7:0] next_rdata;
    logic [5:0] next_claim;
    logic next_pd;

    logic wr_status;
    logic wr_clock;
    logic rd_high;
    logic rd_low;
    logic div_restart;
    logic tick;
    logic [9:0] sample;
    logic [9:0] conv;

    assign wr_status = WR && (ADDR == ACR_OFF_STATUS_CONTROL);
    assign wr_clock = WR && (ADDR == ACR_OFF_CLOCK_CONTROL);
    assign rd_high = RD && (ADDR == ACR_OFF_RESULT_HIGH);
    assign rd_low = RD && (ADDR == ACR_OFF_RESULT_LOW);
    assign div_restart = next_start;
    assign conv = cif.result;

    ////////////////////////////////////////////////////////////////////////
    // Converter clock: bus clock or crystal enable, then the prescaler
    acr_clkdiv u_div (
        .clk(CLK),
        .rst(RST),
        .restart(div_restart),
        .src_en(input_clock_source ? 1'b1 : XTAL_EN),
        .prescale(clock_prescale),
        .tick(tick)
    );

    acr_core u_core (
        .clk(CLK),
        .rst(RST),
        .tick(tick),
        .sample(sample),
        .cif(cif.core)
    );

    ////////////////////////////////////////////////////////////////////////
    // Input mux on the channel latched at start; reserved codes read zero
    always_comb begin
        sample = 10'h000;
        if (cif.channel <= ACR_CH_LAST_PIN) begin
            sample = PIN_SAMPLE[10 * cif.channel +: 10];
        end else if (cif.channel == ACR_CH_BANDGAP) begin
            sample = BANDGAP_SAMPLE;
        end else if (cif.channel == ACR_CH_REF_HIGH) begin
            sample = 10'h3FF;
        end else if (cif.channel == ACR_CH_REF_LOW) begin
            sample = 10'h000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer, control registers and flags
    always_comb begin
        next_state = state;
        next_start = 1'b0;
        next_channel = cif.channel;
        next_done_flag = done_flag;
        next_irq = irq_q;
        next_ien = done_interrupt_enable;
        next_cont = continuous_convert;
        next_input_select = input_select;
        next_prescale = clock_prescale;
        next_source = input_clock_source;
        next_justify = justify;
        next_high = result_high_byte;
        next_low = result_low_byte;
        next_frozen = frozen;
        // Clears first so that a finishing conversion in the same cycle wins over a clock write or low read
        if (wr_status || wr_clock || rd_low) begin
            next_done_flag = 1'b0;
        end
        if (wr_status || rd_low) begin
            next_irq = 1'b0;
        end
        if (rd_low) begin
            next_frozen = 1'b0;
        end
        if (rd_high && justify != ACR_JUST_TRUNC) begin
            next_frozen = 1'b1;
        end
        if (wr_clock) begin
            next_prescale = WDATA[ACR_POS_PRESCALE +: 3];
            next_source = WDATA[ACR_POS_SOURCE];
            next_justify = acr_just_t'(WDATA[ACR_POS_JUST +: 2]);
        end
        case (state)
            ACR_ST_IDLE, ACR_ST_OFF: begin
            end
            ACR_ST_RUN: begin
                if (cif.done) begin
                    if (done_interrupt_enable) begin
                        next_irq = 1'b1;
                    end else begin
                        next_done_flag = 1'b1;
                    end
                    // Ten-bit modes drop results while frozen; a high read landing
                    // now freezes too, else the low byte would not match it
                    if (justify == ACR_JUST_TRUNC) begin
                        next_high = 8'h00;
                        next_low = conv[9:2];
                    end else if (!frozen && !rd_high) begin
                        case (justify)
                            ACR_JUST_RIGHT: begin
                                next_high = {6'h00, conv[9:8]};
                                next_low = conv[7:0];
                            end
                            ACR_JUST_LEFT: begin
                                next_high = conv[9:2];
                                next_low = {conv[1:0], 6'h00};
                            end
                            default: begin
                                next_high = {~conv[9], conv[8:2]};
                                next_low = {conv[1:0], 6'h00};
                            end
                        endcase
                    end
                    if (continuous_convert) begin
                        next_start = 1'b1;
                    end else begin
                        next_state = ACR_ST_IDLE;
                    end
                end
            end
            default: begin
                next_state = ACR_ST_IDLE;
            end
        endcase
        // A status write overrides flags and sequencer: abort, then restart unless powering off
        if (wr_status) begin
            // Abort also beats a conversion finishing in the same cycle
            next_done_flag = 1'b0;
            next_irq = 1'b0;
            next_ien = WDATA[ACR_POS_IEN];
            next_cont = WDATA[ACR_POS_CONT];
            next_input_select = WDATA[4:0];
            if (WDATA[4:0] == ACR_CH_POWER_OFF) begin
                next_state = ACR_ST_OFF;
                next_start = 1'b0;
            end else begin
                next_state = ACR_ST_RUN;
                next_start = 1'b1;
                next_channel = WDATA[4:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data and pin-side outputs; flag reads zero when interrupts enabled
    always_comb begin
        next_rdata = 8'h00;
        if (RD) begin
            case (ADDR)
                ACR_OFF_STATUS_CONTROL: begin
                    next_rdata = {done_flag & ~done_interrupt_enable,
                                  done_interrupt_enable, continuous_convert, input_select};
                end
                ACR_OFF_RESULT_HIGH: next_rdata = result_high_byte;
                ACR_OFF_RESULT_LOW: next_rdata = result_low_byte;
                ACR_OFF_CLOCK_CONTROL: begin
                    next_rdata = {clock_prescale, input_clock_source, justify, 2'h0};
                end
                default: next_rdata = 8'h00;
            endcase
        end
        next_claim = 6'h00;
        if (next_input_select <= ACR_CH_LAST_PIN) begin
            next_claim[next_input_select[2:0]] = 1'b1;
        end
        next_pd = (next_state == ACR_ST_OFF);
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            state <= ACR_ST_OFF;
            cif.start <= 1'b0;
            cif.channel <= ACR_RST_INPUT_SELECT;
            done_flag <= 1'b0;
            done_interrupt_enable <= 1'b0;
            continuous_convert <= 1'b0;
            input_select <= ACR_RST_INPUT_SELECT;
            clock_prescale <= ACR_RST_PRESCALE;
            input_clock_source <= 1'b0;
            justify <= acr_just_t'(ACR_RST_JUST);
            result_high_byte <= ACR_RST_RESULT;
            result_low_byte <= ACR_RST_RESULT;
            frozen <= 1'b0;
            irq_q <= 1'b0;
            RDATA <= 8'h00;
            PIN_CLAIM <= 6'h00;
            POWER_DOWN <= 1'b1;
        end else begin
            state <= next_state;
            cif.start <= next_start;
            cif.channel <= next_channel;
            done_flag <= next_done_flag;
            done_interrupt_enable <= next_ien;
            continuous_convert <= next_cont;
            input_select <= next_input_select;
            clock_prescale <= next_prescale;
            input_clock_source <= next_source;
            justify <= next_justify;
            result_high_byte <= next_high;
            result_low_byte <= next_low;
            frozen <= next_frozen;
            irq_q <= next_irq;
            RDATA <= next_rdata;
            PIN_CLAIM <= next_claim;
            POWER_DOWN <= next_pd;
        end
    end

    assign IRQ = irq_q;
endmodule : acr_top

// ---- dv/acr_xtal_model.sv ----
// Crystal clock stand-in: a one-cycle enable pulse every PERIOD bus cycles.
// Assumes the bus clock runs faster than the crystal clock it stands for.
`timescale 1ns/10ps
module acr_xtal_model #(
    parameter int PERIOD = 4
) (
    input wire logic clk,
    input wire logic rst,
    output logic xtal_en
);
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    ////////////////////////////////////////////////////////////////////////////
    // Free-running divider, the crystal never stops between conversions
    always_comb begin
        next_cnt = (rst || cnt == 8'(PERIOD - 1)) ? 8'h00 : cnt + 8'h01;
    end
    always_ff @(posedge clk) begin
        cnt <= next_cnt;
    end
    assign xtal_en = (cnt == 8'h00) && !rst; // One pulse per crystal period
endmodule : acr_xtal_model

// ---- dv/acr_top_chk.sv ----
// Port-level checks of the converter control and result register block.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/10ps
module acr_top_chk
    import acr_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    input wire logic XTAL_EN,
    input wire logic [59:0] PIN_SAMPLE,
    input wire logic [9:0] BANDGAP_SAMPLE,
    input wire logic IRQ,
    input wire logic [5:0] PIN_CLAIM,
    input wire logic POWER_DOWN
);
    logic [6:0] ctrl;
    logic [6:0] next_ctrl;
    ////////////////////////////////////////////////////////////////////////////
    // Shadow of writable status bits, reset to power-off
    always_comb begin
        next_ctrl = ctrl;
        if (RST) begin
            next_ctrl = 7'h1F;
        end else if (WR && ADDR == ACR_OFF_STATUS_CONTROL) begin
            next_ctrl = WDATA[6:0];
        end
    end
    always_ff @(posedge CLK) begin
        ctrl <= next_ctrl;
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    sequence s_status_wr;
        WR && ADDR == ACR_OFF_STATUS_CONTROL;
    endsequence
    sequence s_low_rd;
        RD && ADDR == ACR_OFF_RESULT_LOW;
    endsequence
    // Select unchanged for two cycles, so registered outputs have caught up
    sequence s_sel_settled;
        ctrl[4:0] == $past(ctrl[4:0]) && ctrl[4:0] == $past(ctrl[4:0], 2);
    endsequence
    a_rdata_idle: assert property (!RD |=> RDATA == 8'h00)
        else $error("read data not zero outside read answer");
    a_reset_state: assert property ($fell(RST) |-> !IRQ && POWER_DOWN && PIN_CLAIM == 6'h00)
        else $error("outputs wrong after reset");
    a_status_back: assert property (RD && ADDR == ACR_OFF_STATUS_CONTROL |=> RDATA[6:0] == $past(ctrl))
        else $error("status control readback wrong");
    a_flag_masked: assert property (RD && ADDR == ACR_OFF_STATUS_CONTROL && ctrl[6] |=> !RDATA[7])
        else $error("done flag visible with interrupt enabled");
    a_write_quiets: assert property (s_status_wr |=> !IRQ [*8])
        else $error("interrupt present too soon after status write");
    a_low_rd_clears: assert property (s_low_rd |=> !IRQ)
        else $error("interrupt not withdrawn by low byte read");
    a_irq_enable: assert property ($rose(IRQ) |-> ctrl[6])
        else $error("interrupt raised while disabled");
    a_power_state: assert property (s_sel_settled |-> POWER_DOWN == (ctrl[4:0] == ACR_CH_POWER_OFF))
        else $error("power down does not follow select");
    a_pin_claim: assert property (s_sel_settled |-> PIN_CLAIM ==
        ((ctrl[4:0] <= ACR_CH_LAST_PIN) ? (6'h01 << ctrl[4:0]) : 6'h00))
        else $error("pin claim does not follow select");
endmodule : acr_top_chk
bind acr_top acr_top_chk u_chk (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .XTAL_EN(XTAL_EN), .PIN_SAMPLE(PIN_SAMPLE),
    .BANDGAP_SAMPLE(BANDGAP_SAMPLE), .IRQ(IRQ), .PIN_CLAIM(PIN_CLAIM), .POWER_DOWN(POWER_DOWN));

// ---- dv/acr_top_tb.sv ----
// Self-checking bench for the converter register block, random samples.
// Assumes the crystal model and the bound port checker beside the design.
`timescale 1ns/10ps
module acr_top_tb import acr_pkg::*;;
    logic CLK, RST, WR, RD, XTAL_EN, IRQ, POWER_DOWN;
    logic [7:0] ADDR, WDATA, RDATA, hi, lo, st;
    logic [59:0] PIN_SAMPLE;
    logic [9:0] BANDGAP_SAMPLE, old;
    logic [5:0] PIN_CLAIM;
    logic [31:0] seed;
    logic [15:0] ex;
    logic [4:0] tab [9] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h1A, 5'h1D, 5'h1E};
    int mismatches, checks, cycles, n, d;
    acr_top DUT (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .XTAL_EN(XTAL_EN), .PIN_SAMPLE(PIN_SAMPLE),
        .BANDGAP_SAMPLE(BANDGAP_SAMPLE), .IRQ(IRQ), .PIN_CLAIM(PIN_CLAIM),
        .POWER_DOWN(POWER_DOWN));
    acr_xtal_model u_xtal (.clk(CLK), .rst(RST), .xtal_en(XTAL_EN));
    ////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial begin
        CLK = 1'b0;
        forever #2.5 CLK = ~CLK;
    end
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    // Analog code the core should see on a channel
    function logic [9:0] sval(logic [4:0] ch);
        if (ch <= 5'h05) return PIN_SAMPLE[ch * 10 +: 10];
        if (ch == ACR_CH_BANDGAP) return BANDGAP_SAMPLE;
        if (ch == ACR_CH_REF_HIGH) return 10'h3FF;
        return 10'h000;
    endfunction : sval
    // High and low byte for a justification mode
    function automatic logic [15:0] fmt(logic [1:0] m, logic [9:0] v);
        case (m)
            2'h0: return {8'h00, v[9:2]};
            2'h1: return {6'h00, v};
            2'h2: return {v, 6'h00};
            default: return {~v[9], v[8:0], 6'h00};
        endcase
    endfunction : fmt
    task tally_and_finish();
        if (mismatches == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= v;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask : wr
    // Read data lands one cycle after the strobe, sampled once settled
    task rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1 v = RDATA;
    endtask : rd
    task newsamp();
        @(posedge CLK);
        seed = xs(seed);
        PIN_SAMPLE[31:0] <= seed;
        seed = xs(seed);
        PIN_SAMPLE[59:32] <= seed[27:0];
        BANDGAP_SAMPLE <= seed[31:22];
    endtask : newsamp
    // Bounded poll of the done flag
    task wait_done();
        st = 8'h00;
        for (int i = 0; i < 300 && st[7] !== 1'b1; i++) rd(ACR_OFF_STATUS_CONTROL, st);
        chk("done_flag_set", 8'h01, {7'h00, st[7]});
    endtask : wait_done
    task conv_check(input logic [7:0] cc, input logic [4:0] ch);
        wr(ACR_OFF_CLOCK_CONTROL, cc);
        wr(ACR_OFF_STATUS_CONTROL, {3'h0, ch});
        wait_done();
        rd(ACR_OFF_RESULT_HIGH, hi);
        rd(ACR_OFF_RESULT_LOW, lo);
        ex = fmt(cc[3:2], sval(ch));
        chk("result_high", ex[15:8], hi);
        chk("result_low", ex[7:0], lo);
        rd(ACR_OFF_STATUS_CONTROL, st);
        chk("done_flag_clear", 8'h00, {7'h00, st[7]});
    endtask : conv_check
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {ADDR, WDATA, WR, RD, PIN_SAMPLE, BANDGAP_SAMPLE} = '0;
        {mismatches, checks, cycles} = '0;
        seed = 32'h0000004F;
        RST = 1'b1;
        repeat (6) @(posedge CLK);
        RST <= 1'b0;
        rd(ACR_OFF_STATUS_CONTROL, st);
        chk("status_reset", 8'h1F, st);
        rd(ACR_OFF_CLOCK_CONTROL, st);
        chk("clock_reset", 8'h04, st);
        rd(8'h40, st);
        chk("unmapped", 8'h00, st);
        wr(ACR_OFF_RESULT_HIGH, 8'hFF);
        rd(ACR_OFF_RESULT_HIGH, hi);
        chk("high_read_only", 8'h00, hi);
        rd(ACR_OFF_RESULT_LOW, lo);
        chk("low_reset", 8'h00, lo);
        wr(ACR_OFF_STATUS_CONTROL, 8'h10); // Reserved code, then discard
        wait_done();
        rd(ACR_OFF_RESULT_LOW, lo);
        for (int k = 0; k < 20; k++) begin
            newsamp();
            conv_check({3'h0, k < 17, k[1:0], 2'h0}, (k < 9) ? tab[k] : 5'(seed % 6));
        end
        // Abort mid-conversion, result comes from the new channel
        wr(ACR_OFF_STATUS_CONTROL, 8'h00);
        repeat (6) @(posedge CLK);
        conv_check(8'h14, 5'h03);
        wr(ACR_OFF_STATUS_CONTROL, 8'h02);
        wait_done();
        wr(ACR_OFF_CLOCK_CONTROL, 8'h14);
        // Long enough for a second conversion, which single mode must not make
        repeat (40) @(posedge CLK);
        rd(ACR_OFF_STATUS_CONTROL, st);
        chk("flag_after_clock_write", 8'h00, {7'h00, st[7]});
        // Interrupt latency over every prescale code
        for (int c = 0; c < 8; c++) begin
            d = c[2] ? 16 : (1 << c);
            wr(ACR_OFF_CLOCK_CONTROL, {c[2:0], 5'h14});
            wr(ACR_OFF_STATUS_CONTROL, 8'h41);
            for (n = 0; n < 400 && IRQ !== 1'b1; n++) @(posedge CLK) #1;
            checks++;
            if (n < 16 * d || n > 17 * d + 4) begin
                mismatches++;
                $display("ERROR irq_latency expected %0d seen %0d", 16 * d, n);
            end
            rd(ACR_OFF_STATUS_CONTROL, st);
            chk("flag_masked", 8'h00, {7'h00, st[7]});
            rd(ACR_OFF_RESULT_LOW, lo);
            chk("irq_cleared", 8'h00, {7'h00, IRQ});
        end
        // Continuous run: interlock in ten-bit mode, none when truncated
        for (int m = 0; m < 2; m++) begin
            wr(ACR_OFF_CLOCK_CONTROL, {4'h1, m[1:0], 2'h0});
            wr(ACR_OFF_STATUS_CONTROL, 8'h20);
            wait_done();
            rd(ACR_OFF_RESULT_HIGH, hi);
            old = sval(5'h00);
            newsamp();
            repeat (60) @(posedge CLK);
            rd(ACR_OFF_RESULT_LOW, lo);
            ex = fmt(m[1:0], (m == 1) ? old : sval(5'h00));
            chk("frozen_low", ex[7:0], lo);
            wait_done();
            rd(ACR_OFF_RESULT_HIGH, hi);
            rd(ACR_OFF_RESULT_LOW, lo);
            ex = fmt(m[1:0], sval(5'h00));
            chk("refreshed_high", ex[15:8], hi);
        end
        wr(ACR_OFF_STATUS_CONTROL, 8'h1F);
        repeat (4) @(posedge CLK);
        tally_and_finish();
    end
endmodule : acr_top_tb
